// *** rtl/fdcr_defs.svh ***
`ifndef FDCR_DEFS_SVH
`define FDCR_DEFS_SVH

// register indices on the word bus; byte address is four times the index
`define FDCR_IDX_STATUS_B    14'h03F1
`define FDCR_IDX_DRV_OUT     14'h03F2
`define FDCR_IDX_TAPE        14'h03F3
`define FDCR_IDX_DIG_IN      14'h03F7
`define FDCR_IDX_MODE_CFG    14'h0400
`define FDCR_IDX_DTYPE_CFG   14'h0401

// drive_output_control field positions
`define FDCR_DOC_SEL_LSB     0
`define FDCR_DOC_SRST_BIT    2
`define FDCR_DOC_DMA_BIT     3
`define FDCR_DOC_MOT0_BIT    4
`define FDCR_DOC_MOT1_BIT    5

// mode configuration field positions
`define FDCR_MCFG_MODE_LSB   0
`define FDCR_MCFG_SWAP_BIT   2
`define FDCR_MCFG_ENH_BIT    3
`define FDCR_MCFG_BOOT_LSB   4

// reset values
`define FDCR_DOC_RST         8'h00
`define FDCR_MCFG_RST        8'h00
`define FDCR_DTYPE_RST       8'h00
`define FDCR_TAPE_RST        2'h0

// timing: shortest soft reset pulse, rounded up to whole clock cycles
`define FDCR_CLK_PERIOD_NS   5
`define FDCR_SWRST_MIN_NS    100
`define FDCR_SWRST_CYC       ((`FDCR_SWRST_MIN_NS + `FDCR_CLK_PERIOD_NS - 1) / `FDCR_CLK_PERIOD_NS)

`endif

// *** rtl/fdcr_pkg.sv ***
package fdcr_pkg;

	// compatibility personality of the status and pin-enable logic
	typedef enum logic [1:0]
	{
		FDCR_MODE_BASE = 2'h0,
		FDCR_MODE_A    = 2'h1,
		FDCR_MODE_B    = 2'h2
	} fdcr_mode_t;

endpackage

// *** rtl/fdcr_dec_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// carries drive-output-control fields to the two-drive decoder and back
interface fdcr_dec_if;
	logic [1:0] dsel;   // binary drive field
	logic [1:0] mot;    // motor enables for drive 0 and 1
	logic       swap;   // drives 0 and 1 exchanged
	logic [1:0] ds_n;   // registered select outputs, active low
	logic [1:0] mtr_n;  // registered motor outputs, active low

	modport ctl (output dsel, output mot, output swap, input ds_n, input mtr_n);
	modport dec (input dsel, input mot, input swap, output ds_n, output mtr_n);
endinterface

`default_nettype wire

// *** rtl/fdcr_drive_decode.sv ***
`timescale 1ns/1ps
`default_nettype none

module fdcr_drive_decode
(
	input  wire logic mclk,
	input  wire logic rst,
	fdcr_dec_if.dec   dif
);

	logic [1:0] ds_n_nxt;   // select lines before the output flops
	logic [1:0] mtr_n_nxt;  // motor lines before the output flops
	logic [1:0] ds_n_r;
	logic [1:0] mtr_n_r;

	// binary field means only one select can ever go low
	always_comb
	begin
		ds_n_nxt  = 2'h3;
		mtr_n_nxt = 2'h3;
		if (!dif.swap)
		begin
			// normal arrangement
			ds_n_nxt[0]  = ~(dif.dsel == 2'h0 && dif.mot[0]);
			ds_n_nxt[1]  = ~(dif.dsel == 2'h1 && dif.mot[1]);
			mtr_n_nxt    = ~dif.mot;
		end
		else
		begin
			// drives exchanged; fields 2 and 3 reach no pin
			ds_n_nxt[1]  = ~(dif.dsel == 2'h0 && dif.mot[0]);
			ds_n_nxt[0]  = ~(dif.dsel == 2'h1 && dif.mot[1]);
			mtr_n_nxt[0] = ~dif.mot[1];
			mtr_n_nxt[1] = ~dif.mot[0];
		end
	end

	// pins come straight from flops, idle high after reset
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ds_n_r  <= 2'h3;
			mtr_n_r <= 2'h3;
		end
		else
		begin
			ds_n_r  <= ds_n_nxt;
			mtr_n_r <= mtr_n_nxt;
		end
	end

	assign dif.ds_n  = ds_n_r;
	assign dif.mtr_n = mtr_n_r;

	a_one_select_low: assert property (@(posedge mclk) disable iff (rst) ds_n_r != 2'h0)
		else $error("both drive selects low");

endmodule

`default_nettype wire

// *** rtl/fdcr_regs.sv ***
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fdcr_defs.svh"

// How it works
// - mode A status bit5 mirrors drive-select bit0
// - mode A status bits 6,7 read one
// - mode B status bits 0,1,7 read one
// - mode B bit2 latches write-gate rise, clears
// - mode B bit3 latches read-data fall, clears
// - mode B bit4 latches write-data fall, clears
// - mode B bits 5,6 show select pin levels
// - output control always writable, soft reset-proof
// - drive field decodes to one select
// - bit2 low holds controller in reset
// - soft reset pulse stretched to 100ns
// - baseline/B: DMA bit gates DMA, irq pins
// - mode A: pins always enabled, bit cleared
// - motor bits 4,5 drive motor pins
// - motor bits 6,7 read zero
// - tape field names drive 1..3 or none
// - normal tape bits 7:2 read zero, soft-reset-proof
// - normal decode of selects and motors
// - swapped decode exchanges drives 0 and 1
// - enhanced tape layout: type, boot, select
// - drive type picked from config pair by field
module fdcr_regs
	import fdcr_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [15:0] ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	input  wire logic        WRITE_GATE,
	input  wire logic        READ_DATA,
	input  wire logic        WRITE_DATA,
	input  wire logic        DMA_REQ_IN,
	input  wire logic        IRQ_IN,
	input  wire logic        DMA_ACK_IN_N,
	input  wire logic        TERM_COUNT_IN,
	output logic             DMA_REQ,
	output logic             DMA_REQ_OE,
	output logic             FLOPPY_IRQ,
	output logic             FLOPPY_IRQ_OE,
	output logic             DMA_ACK_N,
	output logic             TERM_COUNT,
	output logic             SOFT_RESET_N,
	output logic [1:0]       TAPE_SELECT,
	output logic             DRIVE0_SELECT_N,
	output logic             DRIVE1_SELECT_N,
	output logic             DRIVE0_MOTOR_N,
	output logic             DRIVE1_MOTOR_N
);

	// pulse stretch length for the soft reset output
	localparam logic [4:0] SWRST_CYC = 5'(`FDCR_SWRST_CYC);

	// edge polarity per monitored line: write gate active-going, data lines inactive-going
	localparam logic [2:0] EDGE_RISE = 3'h1;

	fdcr_dec_if dif ();

	logic        ack_r;          // wishbone acknowledge
	logic [31:0] dat_r;          // read data register
	logic [5:0]  doc_r;          // drive_output_control bits 5:0
	logic [1:0]  tape_r;         // tape_assign select field
	logic [7:0]  mcfg_r;         // mode configuration
	logic [7:0]  dtype_r;        // drive_type_config pairs
	logic [4:0]  swrst_cnt_r;    // remaining stretch cycles
	logic        swrst_n_r;      // soft reset output
	logic [2:0]  mon_q_r;        // previous samples of monitored lines
	logic [2:0]  mon_lat_r;      // mode B latches: wdata, rdata, write_gate
	logic [1:0]  mon_tog_r;      // mode A toggles: wdata, rdata
	logic        write_gate_q_r;      // write gate level for mode A
	logic        dma_req_r;
	logic        dma_req_oe_r;
	logic        irq_r;
	logic        irq_oe_r;
	logic        dack_n_r;
	logic        tc_r;
	logic [1:0]  tape_sel_r;

	logic        bus_req;        // request present and not yet answered
	logic        bus_take;       // the edge where the master samples ack
	logic        wr_take;
	logic        rd_take;
	logic [13:0] idx;            // word index
	logic [2:0]  mon_now;
	logic [2:0]  mon_evt;        // qualified edge events per line
	logic        dir_rd;         // digital input register read clears latches
	logic        swrst_wr;       // write that drops the reset bit
	logic        pins_on;        // DMA and interrupt pins enabled
	fdcr_mode_t  mode;
	logic [7:0]  srb_val;
	logic [7:0]  tape_val;
	logic [31:0] dat_nxt;

	assign idx      = ADR_I[15:2];
	assign bus_req  = CYC_I && STB_I && !ack_r;
	assign bus_take = CYC_I && STB_I && ack_r;
	assign wr_take  = bus_take && WE_I && SEL_I[0];
	assign rd_take  = bus_take && !WE_I;
	assign mode     = fdcr_mode_t'(mcfg_r[`FDCR_MCFG_MODE_LSB +: 2]);
	assign mon_now  = {WRITE_DATA, READ_DATA, WRITE_GATE};
	assign dir_rd   = rd_take && idx == `FDCR_IDX_DIG_IN;
	assign swrst_wr = wr_take && idx == `FDCR_IDX_DRV_OUT && !DAT_I[`FDCR_DOC_SRST_BIT];

	// mode A keeps the pins alive regardless of the enable bit
	assign pins_on  = (mode == FDCR_MODE_A) || doc_r[`FDCR_DOC_DMA_BIT];

	// wishbone acknowledge: one cycle after the request, dropped the next
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req;
	end

	// drive_output_control: hardware reset only; soft reset never touches it
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			doc_r <= 6'(`FDCR_DOC_RST);
		else if (wr_take && idx == `FDCR_IDX_DRV_OUT)
			doc_r <= DAT_I[5:0];
	end

	// tape_assign select field, also untouched by soft reset
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			tape_r <= `FDCR_TAPE_RST;
		else if (wr_take && idx == `FDCR_IDX_TAPE)
			tape_r <= DAT_I[1:0];
	end

	// configuration registers: mode, swap, layout, boot drive, drive types
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			mcfg_r  <= `FDCR_MCFG_RST;
			dtype_r <= `FDCR_DTYPE_RST;
		end
		else if (wr_take && idx == `FDCR_IDX_MODE_CFG)
			mcfg_r  <= DAT_I[7:0];
		else if (wr_take && idx == `FDCR_IDX_DTYPE_CFG)
			dtype_r <= DAT_I[7:0];
	end

	// soft reset: held while the bit is low, and stretched so two quick
	// writes still give the controller a full-length pulse
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			swrst_cnt_r <= 5'h00;
			swrst_n_r   <= 1'b0;
		end
		else
		begin
			if (swrst_wr)
				swrst_cnt_r <= SWRST_CYC;
			else if (swrst_cnt_r != 5'h00)
				swrst_cnt_r <= swrst_cnt_r - 5'h01;
			// low while bit is clear or stretch still running
			swrst_n_r <= doc_r[`FDCR_DOC_SRST_BIT] && !swrst_wr && swrst_cnt_r <= 5'h01;
		end
	end

	// previous samples of the monitored core lines
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			mon_q_r   <= 3'h0;
			write_gate_q_r <= 1'b0;
		end
		else
		begin
			mon_q_r   <= mon_now;
			write_gate_q_r <= WRITE_GATE;
		end
	end

	// one edge latch per line; set wins over a clearing read in the same cycle
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_mon
			assign mon_evt[i] = EDGE_RISE[i] ? (mon_now[i] && !mon_q_r[i])
			                                 : (!mon_now[i] && mon_q_r[i]);

			always_ff @(posedge MCLK or posedge RST)
			begin
				if (RST)
					mon_lat_r[i] <= 1'b0;
				else if (mon_evt[i])
					mon_lat_r[i] <= 1'b1;
				else if (dir_rd)
					mon_lat_r[i] <= 1'b0;
			end
		end
	endgenerate

	// mode A toggles flip on each inactive data edge
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			mon_tog_r <= 2'h0;
		else
			mon_tog_r <= mon_tog_r ^ mon_evt[2:1];
	end

	// DMA and interrupt pin gating; disabled acknowledge and count read idle
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			dma_req_r    <= 1'b0;
			dma_req_oe_r <= 1'b0;
			irq_r        <= 1'b0;
			irq_oe_r     <= 1'b0;
			dack_n_r     <= 1'b1;
			tc_r         <= 1'b0;
		end
		else
		begin
			dma_req_r    <= DMA_REQ_IN;
			dma_req_oe_r <= pins_on;
			irq_r        <= IRQ_IN;
			irq_oe_r     <= pins_on;
			dack_n_r     <= pins_on ? DMA_ACK_IN_N : 1'b1;
			tc_r         <= pins_on && TERM_COUNT_IN;
		end
	end

	// tape drive assignment reaches the core as a level
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			tape_sel_r <= `FDCR_TAPE_RST;
		else
			tape_sel_r <= tape_r;
	end

	// second status register per compatibility mode
	always_comb
	begin
		srb_val = 8'h00;
		case (mode)
			FDCR_MODE_A:
			begin
				srb_val[7:6] = 2'h3;
				srb_val[5]   = doc_r[`FDCR_DOC_SEL_LSB];
				srb_val[4:3] = {mon_tog_r[1], mon_tog_r[0]};
				srb_val[2]   = write_gate_q_r;
				srb_val[1]   = doc_r[`FDCR_DOC_MOT1_BIT];
				srb_val[0]   = doc_r[`FDCR_DOC_MOT0_BIT];
			end
			FDCR_MODE_B:
			begin
				srb_val[7]   = 1'b1;
				srb_val[6]   = dif.ds_n[1];
				srb_val[5]   = dif.ds_n[0];
				srb_val[4:2] = mon_lat_r;
				srb_val[1:0] = 2'h3;
			end
			default:
				srb_val = 8'h00; // baseline: bus not driven, reads zero
		endcase
	end

	// tape register read: enhanced layout or bare select field
	always_comb
	begin
		tape_val = {6'h00, tape_r};
		if (mcfg_r[`FDCR_MCFG_ENH_BIT])
		begin
			tape_val[5:4] = dtype_r[{doc_r[1:0], 1'b0} +: 2];
			tape_val[3:2] = mcfg_r[`FDCR_MCFG_BOOT_LSB +: 2];
		end
	end

	// read multiplexer; unmapped words answer zero
	always_comb
	begin
		dat_nxt = 32'h0000_0000;
		case (idx)
			`FDCR_IDX_STATUS_B:
				dat_nxt[7:0] = srb_val;
			`FDCR_IDX_DRV_OUT:
				dat_nxt[7:0] = {2'h0, doc_r};
			`FDCR_IDX_TAPE:
				dat_nxt[7:0] = tape_val;
			`FDCR_IDX_MODE_CFG:
				dat_nxt[7:0] = mcfg_r;
			`FDCR_IDX_DTYPE_CFG:
				dat_nxt[7:0] = dtype_r;
			default:
				dat_nxt = 32'h0000_0000;
		endcase
	end

	// read data registered alongside the acknowledge
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			dat_r <= 32'h0000_0000;
		else if (bus_req && !WE_I)
			dat_r <= dat_nxt;
	end

	// register fields feed the two-drive decoder
	assign dif.dsel = doc_r[`FDCR_DOC_SEL_LSB +: 2];
	assign dif.mot  = {doc_r[`FDCR_DOC_MOT1_BIT], doc_r[`FDCR_DOC_MOT0_BIT]};
	assign dif.swap = mcfg_r[`FDCR_MCFG_SWAP_BIT];

	fdcr_drive_decode u_dec
	(
		.mclk (MCLK),
		.rst  (RST),
		.dif  (dif)
	);

	assign DAT_O           = dat_r;
	assign ACK_O           = ack_r;
	assign DMA_REQ         = dma_req_r;
	assign DMA_REQ_OE      = dma_req_oe_r;
	assign FLOPPY_IRQ      = irq_r;
	assign FLOPPY_IRQ_OE   = irq_oe_r;
	assign DMA_ACK_N       = dack_n_r;
	assign TERM_COUNT      = tc_r;
	assign SOFT_RESET_N    = swrst_n_r;
	assign TAPE_SELECT     = tape_sel_r;
	assign DRIVE0_SELECT_N = dif.ds_n[0];
	assign DRIVE1_SELECT_N = dif.ds_n[1];
	assign DRIVE0_MOTOR_N  = dif.mtr_n[0];
	assign DRIVE1_MOTOR_N  = dif.mtr_n[1];

	// helper: cycles the soft reset output has been low in a row
	logic [4:0] swrst_low_cnt;
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			swrst_low_cnt <= 5'h00;
		else if (swrst_n_r)
			swrst_low_cnt <= 5'h00;
		else if (swrst_low_cnt != 5'h1F)
			swrst_low_cnt <= swrst_low_cnt + 5'h01;
	end

	a_srst_min_width: assert property (@(posedge MCLK) disable iff (RST)
		$rose(swrst_n_r) |-> $past(swrst_low_cnt) >= SWRST_CYC - 5'h01)
		else $error("soft reset pulse shorter than minimum");

	a_srst_follows_bit: assert property (@(posedge MCLK) disable iff (RST)
		swrst_wr |=> !swrst_n_r [*8])
		else $error("soft reset not held after clearing the bit");

	a_srst_keeps_dor: assert property (@(posedge MCLK) disable iff (RST)
		!swrst_n_r && !(wr_take && idx == `FDCR_IDX_DRV_OUT) |=> $stable(doc_r))
		else $error("output control changed without a write");

	a_modea_status_b: assert property (@(posedge MCLK) disable iff (RST)
		mode == FDCR_MODE_A |-> srb_val[7:5] == {2'h3, doc_r[0]})
		else $error("mode A status bits 7:5 wrong");

	a_modeb_fixed_ones: assert property (@(posedge MCLK) disable iff (RST)
		mode == FDCR_MODE_B |-> srb_val[7] && srb_val[1:0] == 2'h3 && srb_val[6:5] == {DRIVE1_SELECT_N, DRIVE0_SELECT_N})
		else $error("mode B fixed bits wrong");

	a_write_gate_latch_set: assert property (@(posedge MCLK) disable iff (RST)
		$rose(WRITE_GATE) |=> mon_lat_r[0])
		else $error("write gate edge not latched");

	a_data_latch_clr: assert property (@(posedge MCLK) disable iff (RST)
		dir_rd && !mon_evt[1] |=> !mon_lat_r[1])
		else $error("read data latch not cleared by input read");

	a_pin_gating: assert property (@(posedge MCLK) disable iff (RST)
		mode != FDCR_MODE_A && !doc_r[`FDCR_DOC_DMA_BIT] && $stable(mode) |=> !DMA_REQ_OE && !FLOPPY_IRQ_OE && !TERM_COUNT)
		else $error("DMA pins active while disabled");

	a_motor_pins: assert property (@(posedge MCLK) disable iff (RST)
		!mcfg_r[`FDCR_MCFG_SWAP_BIT] |=> DRIVE0_MOTOR_N == !$past(doc_r[`FDCR_DOC_MOT0_BIT]))
		else $error("motor pin does not follow its bit");

endmodule

`default_nettype wire

// *** verification/fdcr_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// two drives: a selected drive whose motor is on returns a read-data pulse every eight clocks
module fdcr_drive_model
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [1:0] sel_n,
	input  wire logic [1:0] mtr_n,
	output logic            rdata
);
	logic [2:0] phase_r; // pulse spacing

	// the read line has a pull-down, so an idle drive leaves it low instead of the last bit
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			phase_r <= 3'h0;
			rdata   <= 1'b0;
		end
		else
		begin
			phase_r <= phase_r + 3'h1;
			rdata   <= (|(~sel_n & ~mtr_n)) && (phase_r == 3'h0);
		end
	end
endmodule

`default_nettype wire

// *** verification/fdcr_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fdcr_defs.svh"

module fdcr_regs_tb_top import fdcr_pkg::*;;
	localparam logic [15:0] A_STB = {`FDCR_IDX_STATUS_B, 2'h0};
	localparam logic [15:0] A_DOC = {`FDCR_IDX_DRV_OUT, 2'h0};
	localparam logic [15:0] A_TAP = {`FDCR_IDX_TAPE, 2'h0};
	localparam logic [15:0] A_DIN = {`FDCR_IDX_DIG_IN, 2'h0};
	localparam logic [15:0] A_CFG = {`FDCR_IDX_MODE_CFG, 2'h0};
	localparam logic [15:0] A_DTY = {`FDCR_IDX_DTYPE_CFG, 2'h0};
	logic        mclk, rst, cyc, stb, we, ack, write_gate, wdata, rdata;
	logic        dreq_in, irq_in, dack_in_n, tc_in, dreq, dreq_oe, irq, irq_oe, dack_n, tc;
	logic        srst_n, ds0_n, ds1_n, mt0_n, mt1_n, en, a, b, e0, e1;
	logic [15:0] adr;
	logic [3:0]  sel;
	logic [31:0] dat_i, dat_o;
	logic [1:0]  tsel;
	logic [7:0]  rd;
	int          bad_count, samples_checked, cyc_cnt, lo_cnt;

	fdcr_regs dut (.MCLK(mclk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
		.DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .WRITE_GATE(write_gate), .READ_DATA(rdata), .WRITE_DATA(wdata),
		.DMA_REQ_IN(dreq_in), .IRQ_IN(irq_in), .DMA_ACK_IN_N(dack_in_n), .TERM_COUNT_IN(tc_in), .DMA_REQ(dreq),
		.DMA_REQ_OE(dreq_oe), .FLOPPY_IRQ(irq), .FLOPPY_IRQ_OE(irq_oe), .DMA_ACK_N(dack_n), .TERM_COUNT(tc),
		.SOFT_RESET_N(srst_n), .TAPE_SELECT(tsel), .DRIVE0_SELECT_N(ds0_n), .DRIVE1_SELECT_N(ds1_n),
		.DRIVE0_MOTOR_N(mt0_n), .DRIVE1_MOTOR_N(mt1_n));

	fdcr_drive_model drv (.mclk(mclk), .rst(rst), .sel_n({ds1_n, ds0_n}), .mtr_n({mt1_n, mt0_n}), .rdata(rdata));

	// clock, 5 ns period
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// verdict, reached from the main sequence or the timeout
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle; two idle edges first keep the three-cycle spacing
	task automatic bus(input logic [15:0] ad, input logic w, input logic [7:0] d);
		repeat (2) @(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dat_i <= {24'h00_0000, d};
		// wait as long as the slave needs; only the global limit ends a hang
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		rd = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] ad, input logic [7:0] exp, input string nm);
		bus(ad, 1'b0, 8'h00);
		chk(nm, rd, exp);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// soft reset low time, and a hang limit
	always @(posedge mclk)
	begin
		cyc_cnt++;
		if (srst_n === 1'b0)
			lo_cnt++;
		if (cyc_cnt == 20000)
		begin
			bad_count++;
			close_out();
		end
	end

	initial
	begin
		{rst, cyc, stb, we, write_gate, wdata} = 6'h01 << 5;
		{dreq_in, irq_in, dack_in_n, tc_in} = 4'hF;
		dack_in_n = 1'b0;
		adr = 16'h0000;
		sel = 4'h1;
		dat_i = 32'h0000_0000;
		wt(3);
		rst <= 1'b0;
		rdchk(A_DOC, 8'h00, "doc_reset");
		rdchk(A_TAP, 8'h00, "tape_reset");
		chk("pins_reset", {3'h0, srst_n, ds0_n, ds1_n, mt0_n, mt1_n}, 8'h0F);
		bus(A_CFG, 1'b1, 8'(FDCR_MODE_A));
		rdchk(A_STB, 8'hC0, "stb_a_reset");
		bus(A_DOC, 1'b1, 8'hF5);
		rdchk(A_DOC, 8'h35, "doc_top_zero");
		bus(A_STB, 1'b0, 8'h00);
		chk("stb_a", rd & 8'hE3, 8'hE3);
		bus(16'h0FC0, 1'b1, 8'hFF);
		rdchk(16'h0FC0, 8'h00, "unmapped");
		$display("test reset and mode A done");
		for (int m = 0; m < 3; m++)
			for (int e = 0; e < 2; e++)
			begin
				bus(A_CFG, 1'b1, 8'(m));
				bus(A_DOC, 1'b1, {4'h0, e[0], 3'h4});
				wt(3);
				en = (m == 1) || e[0];
				chk("dma_pins", {2'h0, dreq_oe, irq_oe, dack_n, tc, dreq & dreq_oe, irq & irq_oe},
					{2'h0, en, en, !en, en, en, en});
			end
		bus(A_CFG, 1'b1, 8'h00);
		bus(A_TAP, 1'b1, 8'hFF);
		rdchk(A_TAP, 8'h03, "tape_normal");
		chk("tape_pins", {6'h00, tsel}, 8'h03);
		bus(A_CFG, 1'b1, 8'h28);
		bus(A_DTY, 1'b1, 8'hE4);
		bus(A_TAP, 1'b1, 8'h02);
		for (int k = 0; k < 4; k++)
		begin
			bus(A_DOC, 1'b1, {6'h01, k[1:0]});
			rdchk(A_TAP, {2'h0, k[1:0], 4'hA}, "tape_enh");
		end
		$display("test dma and tape done");
		for (int s = 0; s < 2; s++)
		begin
			bus(A_CFG, 1'b1, {5'h00, s[0], 2'h2});
			for (int k = 0; k < 4; k++)
				for (int m = 0; m < 4; m++)
				begin
					bus(A_DOC, 1'b1, {2'h0, m[1:0], 2'h1, k[1:0]});
					wt(3);
					a = (k == 0) && m[0];
					b = (k == 1) && m[1];
					e0 = s[0] ? !b : !a;
					e1 = s[0] ? !a : !b;
					chk("decode", {4'h0, ds0_n, ds1_n, mt0_n, mt1_n},
						{4'h0, e0, e1, s[0] ? !m[1] : !m[0], s[0] ? !m[0] : !m[1]});
					bus(A_STB, 1'b0, 8'h00);
					chk("stb_b", rd & 8'hE3, {1'b1, e1, e0, 5'h03});
				end
		end
		$display("test decode done");
		bus(A_CFG, 1'b1, 8'(FDCR_MODE_B));
		bus(A_DOC, 1'b1, 8'h1C);
		wt(3);
		chk("drive0_on", {6'h00, ds0_n, ds1_n}, 8'h01);
		bus(A_DIN, 1'b0, 8'h00);
		wt(10);
		bus(A_STB, 1'b0, 8'h00);
		chk("rdata_latch", {7'h00, rd[3]}, 8'h01);
		bus(A_DOC, 1'b1, 8'h2D);
		wt(3);
		chk("drive1_on", {6'h00, ds0_n, ds1_n}, 8'h02);
		bus(A_DOC, 1'b1, 8'h04);
		wt(10);
		bus(A_DIN, 1'b0, 8'h00);
		wt(10);
		bus(A_STB, 1'b0, 8'h00);
		chk("latch_clear", {5'h00, rd[4:2]}, 8'h00);
		wdata <= 1'b1;
		wt(1);
		wdata <= 1'b0;
		wt(3);
		bus(A_STB, 1'b0, 8'h00);
		chk("wdata_latch", {5'h00, rd[4:2]}, 8'h04);
		bus(A_DIN, 1'b0, 8'h00);
		write_gate <= 1'b1;
		wt(3);
		bus(A_STB, 1'b0, 8'h00);
		chk("write_gate_latch", {5'h00, rd[4:2]}, 8'h01);
		bus(A_DIN, 1'b0, 8'h00);
		bus(A_STB, 1'b0, 8'h00);
		chk("write_gate_level", {5'h00, rd[4:2]}, 8'h00);
		write_gate <= 1'b0;
		$display("test latches done");
		bus(A_DOC, 1'b1, 8'h3D);
		wt(25);
		lo_cnt = 0;
		bus(A_DOC, 1'b1, 8'h39);
		bus(A_DOC, 1'b1, 8'h3D);
		wt(30);
		chk("srst_len", {7'h00, lo_cnt >= 20}, 8'h01);
		chk("srst_end", {7'h00, srst_n}, 8'h01);
		rdchk(A_DOC, 8'h3D, "doc_keep");
		rdchk(A_TAP, 8'h02, "tape_keep");
		chk("sel_keep", {6'h00, ds0_n, ds1_n}, 8'h02);
		$display("test soft reset done");
		close_out();
	end
endmodule

`default_nettype wire
